// ===== rtl/tscrb_pkg.sv
/*
 * Constants, types and helpers for the temperature sensor command decoder
 * and register bank. Assumes a 125 MHz core clock.
 */
package tscrb_pkg;

    // Core clock and conversion timebase
    localparam int CLK_HZ           = 125_000_000;
    localparam int CONV_TIME_MS     = 500;
    localparam int CONV_CYCLES_DFLT = CONV_TIME_MS * (CLK_HZ / 1000);

    // Frame layout
    localparam int          CMD_BITS     = 8;
    localparam int          WORD_BITS    = 16;
    localparam logic [4:0]  BITS_CMD     = 5'h08;
    localparam logic [4:0]  BITS_FRAME   = 5'h18;
    localparam logic [4:0]  BITS_OVER    = 5'h19;
    localparam int          CMD_START    = 7;
    localparam int          CMD_DIR      = 6;

    // Command codes
    localparam logic [7:0] CMD_RD_TEMP = 8'hc1;
    localparam logic [7:0] CMD_RD_CFG  = 8'hc3;
    localparam logic [7:0] CMD_RD_HYST = 8'hc5;
    localparam logic [7:0] CMD_RD_MAX  = 8'hc7;
    localparam logic [7:0] CMD_RD_LOW  = 8'hc9;
    localparam logic [7:0] CMD_RD_HIGH = 8'hcb;
    localparam logic [7:0] CMD_WR_CFG  = 8'h83;
    localparam logic [7:0] CMD_WR_HYST = 8'h85;
    localparam logic [7:0] CMD_WR_MAX  = 8'h87;
    localparam logic [7:0] CMD_WR_LOW  = 8'h89;
    localparam logic [7:0] CMD_WR_HIGH = 8'h8b;

    // Register masks and power-on values
    localparam logic [15:0] CFG_MASK  = 16'h1f00;
    localparam logic [15:0] LIM_MASK  = 16'hff80;
    localparam logic [15:0] CFG_RST   = 16'h0000;
    localparam logic [15:0] HYST_RST  = 16'h0100;
    localparam logic [15:0] MAX_RST   = 16'h2800;
    localparam logic [15:0] LOW_RST   = 16'h0500;
    localparam logic [15:0] HIGH_RST  = 16'h2000;
    localparam logic [15:0] TEMP_RST  = 16'h0000;

    // Field positions
    localparam int CFG_SHDN     = 8;
    localparam int CFG_INTR     = 9;
    localparam int CFG_CRIT_POL = 10;
    localparam int CFG_WARN_POL = 11;
    localparam int CFG_QUEUE    = 12;
    localparam int LIM_LSB      = 7;

    localparam logic [1:0] QUEUE_FULL = 2'h3;

    typedef enum logic [2:0] {
        REG_TEMP = 3'b000,
        REG_CFG  = 3'b001,
        REG_HYST = 3'b010,
        REG_MAX  = 3'b011,
        REG_LOW  = 3'b100,
        REG_HIGH = 3'b101
    } tscrb_reg_e;

    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_CMD  = 2'b01,
        SP_DATA = 2'b10
    } tscrb_state_e;

    typedef enum logic [1:0] {
        WATCH_BOTH = 2'b00,
        WATCH_HCLR = 2'b01,
        WATCH_LCLR = 2'b10
    } tscrb_watch_e;

    // Serial pins as seen by the device
    typedef struct packed {
        logic clk_level;
        logic select_n;
        logic data;
    } tscrb_pins_s;

    localparam tscrb_pins_s PINS_IDLE = 3'b010;

    // Decoded command byte
    typedef struct packed {
        logic       valid;
        logic       rd;
        tscrb_reg_e sel;
    } tscrb_cmd_s;

    // Map a command byte to a register, flagging unknown codes
    function automatic tscrb_cmd_s decode_cmd(input logic [7:0] c);
        tscrb_cmd_s d;
        d.valid = c[CMD_START];
        d.rd    = c[CMD_DIR];
        case (c)
            CMD_RD_TEMP:              d.sel = REG_TEMP;
            CMD_RD_CFG,  CMD_WR_CFG:  d.sel = REG_CFG;
            CMD_RD_HYST, CMD_WR_HYST: d.sel = REG_HYST;
            CMD_RD_MAX,  CMD_WR_MAX:  d.sel = REG_MAX;
            CMD_RD_LOW,  CMD_WR_LOW:  d.sel = REG_LOW;
            CMD_RD_HIGH, CMD_WR_HIGH: d.sel = REG_HIGH;
            default: begin
                d.sel   = REG_TEMP;
                d.valid = 1'b0;
            end
        endcase
        return d;
    endfunction : decode_cmd

    // Temperature code in sixteenths, sign extended for arithmetic
    function automatic logic signed [14:0] temp_ext(input logic [12:0] t);
        return {t[12], t[12], t};
    endfunction : temp_ext

    // Limit in whole degrees rescaled to sixteenths
    function automatic logic signed [14:0] lim_ext(input logic [15:0] l);
        return {l[15], l[15], l[15:LIM_LSB], 4'h0};
    endfunction : lim_ext

endpackage : tscrb_pkg

// ===== rtl/tscrb_bank.sv
/*
 * Command decoder and register bank of a temperature sensor behind a
 * three-wire serial slave port, with conversion timebase and alarms.
 * Assumes the converter result arrives on the core clock; the serial
 * pins are asynchronous and are sampled by the 125 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Command byte must start with 1; a leading 0 is invalid.
// - Second command bit: 1 reads a register, 0 writes one.
// - Only eleven codes act, six reads and five writes.
// - C1h reads the temperature result; it has no write code.
// - C3h reads configuration, 83h writes it.
// - C5h, C7h, C9h, CBh read hysteresis, maximum, low, high limits.
// - 85h, 87h, 89h, 8Bh write hysteresis, maximum, low, high limits.
// - Conversions run continuously on their own timebase.
// - Temperature read aborts conversion and returns previous result.
// - Every valid 24-clock frame, and any temperature read, starts a fresh conversion.
// - Six registers, each sixteen bits, moved as whole words.
// - Temperature result is read-only; the other five read and write.
// - Result bit 15 is sign, bits 14..3 magnitude, two's complement.
// - One result step is one sixteenth of a degree.
// - Result bits 2, 1, 0 flag overtemperature, high and low faults.
// - Only configuration bits 8..12 exist; other written bits dropped.
// - Configuration bit 8 powers down all but serial port and reset.
// - Configuration bit 12 demands four faulty conversions before alarms.
// - High, low, hysteresis drive warning; maximum, hysteresis drive critical.
// - Limits use upper nine bits as signed degrees; low seven ignored.
// - Hysteresis powers up as 2 degrees.
// - Maximum, low, high power up as +80, +10, +64 degrees.
// - A frame is exactly 24 clocks under select; others are ignored, yet reads still drive data and temperature reads still restart conversion.
// - MSB first, sampled on rising edges; reads drive from eighth fall.
// - Config bits 11, 10 set alarm polarities; bit 9 selects latched mode.
// - In latched mode a temperature read releases the warning output.
module tscrb_bank #(
    parameter int unsigned CONV_CYCLES = tscrb_pkg::CONV_CYCLES_DFLT
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Serial pins, asynchronous
    input  wire tscrb_pkg::tscrb_pins_s pins,
    output var  logic              serial_data_line_out,
    output var  logic              serial_data_line_oe,
    // Converter side
    input  wire logic [12:0]       adc_value,
    output var  logic              conv_start,
    output var  logic              powered_down,
    // Alarm pin levels, polarity applied
    output var  logic              warning_output,
    output var  logic              critical_output
);
    import tscrb_pkg::*;

    tscrb_pins_s            pin_s1;
    tscrb_pins_s            pin_s2;
    tscrb_pins_s            pin_s3;
    tscrb_state_e           state;
    logic [4:0]             bit_cnt;
    logic [7:0]             cmd_shift;
    logic [15:0]            data_shift;
    logic [15:0]            out_shift;
    logic                   conv_hold;
    logic [31:0]            conv_cnt;
    logic [15:0]            temperature_result;
    logic [15:0]            device_configuration;
    logic [15:0]            limit_hysteresis;
    logic [15:0]            limit_maximum_critical;
    logic [15:0]            limit_low_warning;
    logic [15:0]            limit_high_warning;
    logic [1:0]             warn_cnt;
    logic [1:0]             crit_cnt;
    logic                   warn_cmp;
    logic                   warn_int;
    logic                   crit_act;
    tscrb_watch_e           watch;

    // Synchronise pins; only stage two onward is looked at
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_s1 <= PINS_IDLE;
            pin_s2 <= PINS_IDLE;
            pin_s3 <= PINS_IDLE;
        end else begin
            pin_s1 <= pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Edge events of the link clock and select
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_active;
    logic       cs_rise;
    tscrb_cmd_s cmd;
    logic       frame_ok;
    logic       temp_read_ok;
    assign sclk_rise    = pin_s2.clk_level & ~pin_s3.clk_level;
    assign sclk_fall    = ~pin_s2.clk_level & pin_s3.clk_level;
    assign cs_active    = ~pin_s2.select_n;
    assign cs_rise      = pin_s2.select_n & ~pin_s3.select_n;
    assign cmd          = decode_cmd(cmd_shift);
    assign frame_ok     = cs_rise && state == SP_DATA && bit_cnt == BITS_FRAME
                          && cmd.valid;
    assign temp_read_ok = frame_ok && cmd.rd && cmd.sel == REG_TEMP;

    // Frame receiver: command byte then data word, MSB first
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state      <= SP_IDLE;
            bit_cnt    <= '0;
            cmd_shift  <= '0;
            data_shift <= '0;
        end else if (!cs_active) begin
            state   <= SP_IDLE;
            bit_cnt <= '0;
        end else if (sclk_rise) begin
            if (bit_cnt != BITS_OVER) begin
                bit_cnt <= bit_cnt + 5'h01; // Saturates so long frames stay bad
            end
            case (state)
                SP_IDLE, SP_CMD: begin
                    cmd_shift <= {cmd_shift[CMD_BITS-2:0], pin_s2.data};
                    state     <= (bit_cnt == BITS_CMD - 5'h01) ? SP_DATA : SP_CMD;
                end
                SP_DATA: begin
                    data_shift <= {data_shift[WORD_BITS-2:0], pin_s2.data};
                end
                default: state <= SP_IDLE;
            endcase
        end
    end

    // Read mux; reserved bits are already zero in storage
    logic [15:0] rd_word;
    always_comb begin
        case (cmd.sel)
            REG_TEMP: rd_word = temperature_result;
            REG_CFG:  rd_word = device_configuration;
            REG_HYST: rd_word = limit_hysteresis;
            REG_MAX:  rd_word = limit_maximum_critical;
            REG_LOW:  rd_word = limit_low_warning;
            REG_HIGH: rd_word = limit_high_warning;
            default:  rd_word = '0;
        endcase
    end

    // Readout driver from the eighth falling edge until select rises
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            serial_data_line_out <= 1'b0;
            serial_data_line_oe  <= 1'b0;
            out_shift            <= '0;
        end else if (!cs_active) begin
            serial_data_line_oe <= 1'b0;
        end else if (sclk_fall && state == SP_DATA && cmd.valid && cmd.rd) begin
            if (bit_cnt == BITS_CMD) begin
                serial_data_line_out <= rd_word[WORD_BITS-1];
                out_shift            <= {rd_word[WORD_BITS-2:0], 1'b0};
                serial_data_line_oe  <= 1'b1;
            end else if (bit_cnt < BITS_FRAME) begin
                serial_data_line_out <= out_shift[WORD_BITS-1];
                out_shift            <= {out_shift[WORD_BITS-2:0], 1'b0};
            end
        end
    end

    // Register writes land only at the end of a good frame
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            device_configuration   <= CFG_RST;
            limit_hysteresis       <= HYST_RST;
            limit_maximum_critical <= MAX_RST;
            limit_low_warning      <= LOW_RST;
            limit_high_warning     <= HIGH_RST;
        end else if (frame_ok && !cmd.rd) begin
            case (cmd.sel)
                REG_CFG:  device_configuration   <= data_shift & CFG_MASK;
                REG_HYST: limit_hysteresis       <= data_shift & LIM_MASK;
                REG_MAX:  limit_maximum_critical <= data_shift & LIM_MASK;
                REG_LOW:  limit_low_warning      <= data_shift & LIM_MASK;
                REG_HIGH: limit_high_warning     <= data_shift & LIM_MASK;
                default:  ;
            endcase
        end
    end

    // Abort: hold the conversion timer from a temperature read until select rises
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            conv_hold <= 1'b0;
        end else if (!cs_active) begin
            conv_hold <= 1'b0;
        end else if (state == SP_DATA && cmd.valid && cmd.rd && cmd.sel == REG_TEMP) begin
            conv_hold <= 1'b1;
        end
    end

    // Conversion timebase, free running apart from access restarts and shutdown
    logic restart;
    logic shdn;
    logic run;
    logic conv_end;
    assign shdn     = device_configuration[CFG_SHDN];
    assign restart  = cs_rise && (frame_ok || conv_hold);
    assign run      = !shdn && !conv_hold && !restart;
    assign conv_end = run && conv_cnt == CONV_CYCLES - 1;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            conv_cnt     <= '0;
            conv_start   <= 1'b0;
            powered_down <= 1'b0;
        end else begin
            conv_start   <= run && conv_cnt == '0;
            powered_down <= shdn;
            if (!run || conv_end) begin
                conv_cnt <= '0;
            end else begin
                conv_cnt <= conv_cnt + 32'h1;
            end
        end
    end

    // Limit comparisons in sixteenths of a degree
    logic signed [14:0] t_now;
    logic signed [14:0] hyst;
    logic               over_f;
    logic               high_f;
    logic               low_f;
    logic               crit_clr;
    logic               high_clr;
    logic               low_clr;
    assign t_now    = temp_ext(adc_value);
    assign hyst     = lim_ext(limit_hysteresis);
    assign over_f   = t_now > lim_ext(limit_maximum_critical);
    assign high_f   = t_now > lim_ext(limit_high_warning);
    assign low_f    = t_now < lim_ext(limit_low_warning);
    assign crit_clr = t_now < lim_ext(limit_maximum_critical) - hyst;
    assign high_clr = t_now < lim_ext(limit_high_warning) - hyst;
    assign low_clr  = t_now > lim_ext(limit_low_warning) + hyst;

    // Result word captured at the end of each conversion
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            temperature_result <= TEMP_RST;
        end else if (conv_end) begin
            temperature_result <= {adc_value, over_f, high_f, low_f};
        end
    end

    // Warning condition depends on mode and, when latched, on what fired last
    logic warn_cond;
    logic queue_en;
    logic warn_q;
    logic crit_q;
    assign queue_en = device_configuration[CFG_QUEUE];
    always_comb begin
        if (!device_configuration[CFG_INTR]) begin
            warn_cond = high_f || low_f;
        end else begin
            case (watch)
                WATCH_HCLR: warn_cond = high_clr;
                WATCH_LCLR: warn_cond = low_clr;
                default:    warn_cond = high_f || low_f;
            endcase
        end
    end
    assign warn_q = warn_cond && (!queue_en || warn_cnt == QUEUE_FULL);
    assign crit_q = over_f && (!queue_en || crit_cnt == QUEUE_FULL);

    // Fault queues count consecutive faulty conversions
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            warn_cnt <= '0;
            crit_cnt <= '0;
        end else if (conv_end) begin
            warn_cnt <= !warn_cond ? 2'h0 : (warn_cnt == QUEUE_FULL ? warn_cnt : warn_cnt + 2'h1);
            crit_cnt <= !over_f ? 2'h0 : (crit_cnt == QUEUE_FULL ? crit_cnt : crit_cnt + 2'h1);
        end
    end

    // Critical alarm, comparator behaviour only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            crit_act <= 1'b0;
        end else if (conv_end) begin
            if (crit_q) begin
                crit_act <= 1'b1;
            end else if (crit_clr) begin
                crit_act <= 1'b0;
            end
        end
    end

    // Warning in comparator behaviour
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            warn_cmp <= 1'b0;
        end else if (conv_end && !device_configuration[CFG_INTR]) begin
            if (warn_q) begin
                warn_cmp <= 1'b1;
            end else if (high_clr && low_clr) begin
                warn_cmp <= 1'b0;
            end
        end
    end

    // Warning in latched behaviour; a new event beats a same-cycle release
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            warn_int <= 1'b0;
            watch    <= WATCH_BOTH;
        end else begin
            if (temp_read_ok) begin
                warn_int <= 1'b0;
            end
            if (conv_end && device_configuration[CFG_INTR] && warn_q) begin
                warn_int <= 1'b1;
                if (watch == WATCH_BOTH) begin
                    watch <= high_f ? WATCH_HCLR : WATCH_LCLR;
                end else begin
                    watch <= WATCH_BOTH;
                end
            end
        end
    end

    // Pin levels; idle low-active pins rest high
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            warning_output  <= 1'b1;
            critical_output <= 1'b1;
        end else begin
            warning_output  <= (device_configuration[CFG_INTR] ? warn_int : warn_cmp)
                               ~^ device_configuration[CFG_WARN_POL];
            critical_output <= crit_act ~^ device_configuration[CFG_CRIT_POL];
        end
    end

endmodule : tscrb_bank

`default_nettype wire

// ===== sim/tscrb_checker.sv
/*
 * Port checker for the sensor register bank: serial drive and timebase.
 * Bound to every tscrb_bank; reset is asynchronous, active high.
 */
`timescale 1ns/1ps
`default_nettype none
module tscrb_checker #(
    parameter int unsigned CONV_CYCLES = 50
) (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   reset,
    // Serial side
    input wire tscrb_pkg::tscrb_pins_s pins,
    input wire logic                   serial_data_line_out,
    input wire logic                   serial_data_line_oe,
    // Converter and alarms
    input wire logic [12:0]            adc_value,
    input wire logic                   conv_start,
    input wire logic                   powered_down,
    input wire logic                   warning_output,
    input wire logic                   critical_output
);
    import tscrb_pkg::*;

    // Cycles since the last start; frames and shutdown clear it, as both may hold the timer
    logic [31:0] idle_cnt;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idle_cnt <= 32'h0;
        end else if (conv_start || powered_down || !pins.select_n) begin
            idle_cnt <= 32'h0;
        end else begin
            idle_cnt <= idle_cnt + 32'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_oe_idle_quiet: assert property (pins.select_n [*5] |-> !serial_data_line_oe)
        else $error("data line driven while deselected");
    a_oe_drops_after: assert property ($rose(pins.select_n) |-> ##[1:5] !serial_data_line_oe)
        else $error("data line not released after select rose");
    a_oe_rise_phase: assert property ($rose(serial_data_line_oe) |-> !pins.clk_level && !pins.select_n)
        else $error("drive began outside a low clock phase");
    a_out_shift_phase: assert property (serial_data_line_oe && $changed(serial_data_line_out)
        |-> !pins.clk_level)
        else $error("output bit moved while serial clock high");
    a_shdn_no_start: assert property (powered_down && $past(powered_down) |-> !conv_start)
        else $error("conversion started in shutdown");
    a_start_one_cycle: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    a_conv_period_bound: assert property (idle_cnt <= CONV_CYCLES + 8)
        else $error("conversion timebase stalled");
    a_shdn_frame_end: assert property ($changed(powered_down) |-> pins.select_n)
        else $error("shutdown changed inside a frame");
endmodule : tscrb_checker

bind tscrb_bank tscrb_checker #(.CONV_CYCLES(CONV_CYCLES)) u_checker (
    .clk(clk), .reset(reset), .pins(pins), .serial_data_line_out(serial_data_line_out),
    .serial_data_line_oe(serial_data_line_oe), .adc_value(adc_value), .conv_start(conv_start),
    .powered_down(powered_down), .warning_output(warning_output),
    .critical_output(critical_output));
`default_nettype wire

// ===== sim/tscrb_master.sv
/*
 * Serial bus master model: 8-bit command then 16-bit word, MSB first.
 * Assumes the core clock as timebase; serial clock period is 20 core cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module tscrb_master (
    // Timebase
    input  wire logic                   clk,
    // Device drive of the data line
    input  wire logic                   dev_out,
    input  wire logic                   dev_oe,
    // Pins and results
    output var  tscrb_pkg::tscrb_pins_s pins,
    output var  logic [15:0]            rdata,
    output var  logic                   drove
);
    import tscrb_pkg::*;
    logic sclk   = 1'b0;
    logic sel_n  = 1'b1;
    logic m_en   = 1'b1;
    logic m_data = 1'b0;
    logic flt    = 1'b0;

    initial begin
        rdata = 16'h0000;
        drove = 1'b0;
    end
    // A released line toggles, so a stale bit can never pass as read data
    always @(posedge clk) flt <= ~flt;
    always @(posedge clk) if (dev_oe) drove <= 1'b1;
    always_comb pins = '{sclk, sel_n, dev_oe ? dev_out : (m_en ? m_data : flt)};

    // One frame of n serial clocks
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int n);
        logic rd;
        rd = cmd[6];
        drove = 1'b0;
        rdata = 16'h0000;
        @(negedge clk);
        sel_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            if (i < 8) m_data = cmd[7 - i];
            else if (!rd && i < 24) m_data = wd[23 - i];
            else m_data = 1'b0;
            if (i == 8 && rd) m_en = 1'b0;
            repeat (10) @(negedge clk);
            sclk = 1'b1;
            if (rd && i >= 8 && i < 24) rdata[23 - i] = pins.data;
            repeat (10) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (10) @(negedge clk);
        sel_n = 1'b1;
        repeat (6) @(negedge clk);
        m_en = 1'b1;
        m_data = 1'b0;
    endtask : xfer
endmodule : tscrb_master
`default_nettype wire

// ===== sim/tscrb_bank_tb.sv
/*
 * Self-checking bench for the sensor register bank, driven through frames.
 * Assumes the master model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tscrb_bank_tb;
    import tscrb_pkg::*;
    localparam int unsigned CONV = 50;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [12:0] adc_value = 13'h0190;
    tscrb_pins_s pins;
    logic        sdo, soe, conv_start, powered_down, warning_output, critical_output, drove;
    logic [15:0] rd_word;
    int          err_count = 0, total_checks = 0, starts = 0;
    logic [7:0]  rcmd [5] = '{8'hc3, 8'hc5, 8'hc7, 8'hc9, 8'hcb};
    logic [15:0] rstv [5] = '{16'h0000, 16'h0100, 16'h2800, 16'h0500, 16'h2000};
    logic [15:0] mskv [5] = '{16'h1f00, 16'hff80, 16'hff80, 16'hff80, 16'hff80};
    logic [7:0]  bad  [5] = '{8'h41, 8'h81, 8'h8d, 8'hc2, 8'h01};
    logic [12:0] adcv [3] = '{13'h0190, 13'h1fb0, 13'h05a0};
    logic [15:0] tv   [3] = '{16'h0c80, 16'hfd81, 16'h2d06};
    logic [2:0]  wv = 3'b001, cv = 3'b011;

    // Core clock and conversion start counter
    always #4 clk = ~clk;
    always @(posedge clk) if (conv_start) starts++;

    tscrb_bank #(.CONV_CYCLES(CONV)) u_dut (
        .clk(clk), .reset(reset), .pins(pins), .serial_data_line_out(sdo),
        .serial_data_line_oe(soe), .adc_value(adc_value), .conv_start(conv_start),
        .powered_down(powered_down), .warning_output(warning_output),
        .critical_output(critical_output));
    tscrb_master u_master (
        .clk(clk), .dev_out(sdo), .dev_oe(soe), .pins(pins), .rdata(rd_word), .drove(drove));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        u_master.xfer(c, 16'h0000, 24);
        chk(rd_word, exp);
    endtask : rd
    task automatic waitc(input int n);
        repeat (n) @(negedge clk);
    endtask : waitc
    task automatic note(input string s);
        $display("test %s done", s);
    endtask : note
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // Main sequence; the alarm pair is packed as {warning, critical}
    initial begin
        waitc(5);
        reset = 1'b0;
        waitc(5);
        for (int k = 0; k < 5; k++) rd(rcmd[k], rstv[k]);
        chk({14'h0, warning_output, critical_output}, 16'h0003);
        note("power-on");
        for (int k = 0; k < 5; k++) begin
            u_master.xfer(rcmd[k] ^ 8'h40, 16'hffff, 24);
            rd(rcmd[k], mskv[k]);
            if (k == 0) begin
                starts = 0;
                waitc(4 * CONV);
                chk({15'h0, powered_down}, 16'h0001);
                chk(16'(starts), 16'h0000);
            end
            u_master.xfer(rcmd[k] ^ 8'h40, rstv[k], 24);
            rd(rcmd[k], rstv[k]);
        end
        note("access");
        for (int k = 0; k < 5; k++) begin
            u_master.xfer(bad[k], 16'hffff, 24);
            chk({15'h0, drove}, 16'h0000);
        end
        u_master.xfer(8'h85, 16'hffff, 23);
        u_master.xfer(8'h85, 16'hffff, 25);
        for (int k = 0; k < 5; k++) rd(rcmd[k], rstv[k]);
        note("refusal");
        for (int i = 0; i < 3; i++) begin
            adc_value = adcv[i];
            waitc(3 * CONV);
            chk({14'h0, warning_output, critical_output}, {14'h0, wv[i], cv[i]});
            rd(8'hc1, tv[i]);
        end
        adc_value = 13'h0190;
        starts = 0;
        waitc(10 * CONV);
        chk({15'h0, starts >= 9 && starts <= 11}, 16'h0001);
        chk({14'h0, warning_output, critical_output}, 16'h0003);
        note("conversion");
        u_master.xfer(8'h83, 16'h0c00, 24);
        waitc(CONV);
        chk({14'h0, warning_output, critical_output}, 16'h0000);
        u_master.xfer(8'h83, 16'h1000, 24);
        adc_value = 13'h05a0;
        waitc(80);
        chk({14'h0, warning_output, critical_output}, 16'h0003);
        waitc(4 * CONV);
        chk({14'h0, warning_output, critical_output}, 16'h0000);
        adc_value = 13'h0190;
        waitc(6 * CONV);
        u_master.xfer(8'h83, 16'h0200, 24);
        adc_value = 13'h05a0;
        waitc(3 * CONV);
        chk({15'h0, warning_output}, 16'h0000);
        rd(8'hc1, 16'h2d06);
        waitc(3 * CONV);
        chk({15'h0, warning_output}, 16'h0001);
        adc_value = 13'h0190;
        waitc(3 * CONV);
        chk({15'h0, warning_output}, 16'h0000);
        note("alarm");
        end_of_test();
    end

    // Watchdog, well beyond the expected run length
    initial begin
        waitc(60000);
        err_count++;
        end_of_test();
    end
endmodule : tscrb_bank_tb
`default_nettype wire
